// ### hw/rx_flags_pkg.sv
/*
 Shared constants and carriers for the receive flag and credit return block.
 Assumes a single 20 MHz clock, a synchronous active-high reset and a classic Wishbone slave port.
*/
package rx_flags_pkg;

	// Clock and update timer
	localparam int CLK_KHZ = 20000;
	localparam int UPDATE_TIMER_NS = 30000;
	localparam int UPDATE_TIMER_CYCLES = (UPDATE_TIMER_NS * CLK_KHZ) / 1000000;

	// Widths
	localparam int REGION_W = 7;
	localparam int COUNT_W = 8;
	localparam int ACCUM_W = 12;
	localparam int IRQ_W = 5;

	////////////////////////////////////////////////////////////////////////////
	// Register map, byte addresses
	localparam logic [7:0] THRESHOLD_OFFSET = 8'h00;
	localparam logic [7:0] PAIR64_OFFSET = 8'h04;
	localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h08;
	localparam logic [7:0] IRQ_MASK_OFFSET = 8'h0c;
	localparam logic [7:0] PENDING_LO_OFFSET = 8'h10;
	localparam logic [7:0] PENDING_HI_OFFSET = 8'h14;

	// Reset values
	localparam logic [ACCUM_W-1:0] THRESHOLD_RESET = 12'h020;
	localparam logic [2:0] PAIR64_RESET = 3'h0;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 5'h00;

	// Interrupt status bit positions
	localparam int IRQ_MALFORMED_BIT = 0;
	localparam int IRQ_UNSUP_TLP_BIT = 1;
	localparam int IRQ_APP_NP_BIT = 2;
	localparam int IRQ_APP_P_BIT = 3;
	localparam int IRQ_FC_SENT_BIT = 4;

	////////////////////////////////////////////////////////////////////////////
	typedef enum logic [1:0] {
		FC_PH = 2'b00,
		FC_PD = 2'b01,
		FC_NPH = 2'b10,
		FC_NPD = 2'b11
	} fc_kind_t;

	typedef enum logic {
		BUS_IDLE = 1'b0,
		BUS_ACK = 1'b1
	} bus_state_t;

	// Header summary from the receive decoder, valid with start
	typedef struct packed {
		logic start;
		logic unsupType;
		logic lenBad;
		logic fmtBad;
		logic [REGION_W-1:0] regionMatch;
	} rx_hdr_t;

	// One flow-control update request toward the DLLP generator
	typedef struct packed {
		logic valid;
		fc_kind_t kind;
		logic [ACCUM_W-1:0] credits;
	} fc_update_t;

endpackage

// ### hw/rx_tlp_flags_credit_return.sv
/*
 Receive-side TLP flags toward user logic, credit return accounting and flow-control update
 scheduling, with a Wishbone register port and one level interrupt.
 Assumes the receive decoder and user logic run on clk; no input needs synchronising.
*/
`timescale 1ns/10ps
module rx_tlp_flags_credit_return #(
	parameter int TIMER_CYCLES = rx_flags_pkg::UPDATE_TIMER_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Receive decoder side
	input wire rx_flags_pkg::rx_hdr_t rxHdrIn,
	// Receive flags toward user logic
	output logic rx_first_beat,
	output logic rx_malformed_flag,
	output logic rx_unsupported_flag,
	output logic [rx_flags_pkg::REGION_W-1:0] rxRegionHit,
	// Credit return from user logic, index 0 posted, 1 non-posted
	input wire logic app_unsup_nonposted,
	input wire logic app_unsup_posted,
	input wire logic [3:0] app_buffer_full,
	input wire logic [1:0] hdr_credit_freed_strobe,
	input wire logic [1:0] data_credit_freed_strobe,
	input wire logic [rx_flags_pkg::COUNT_W-1:0] dataCreditFreedCountP,
	input wire logic [rx_flags_pkg::COUNT_W-1:0] dataCreditFreedCountNp,
	// Update request toward the DLLP generator
	output rx_flags_pkg::fc_update_t fcUpdate,
	// Interrupt
	output logic irq
);

	if (TIMER_CYCLES < 2 || TIMER_CYCLES > 65535) begin
		$error("TIMER_CYCLES out of range");
	end

	localparam logic [15:0] TIMER_LAST = 16'(TIMER_CYCLES - 1);
	localparam logic [rx_flags_pkg::ACCUM_W-1:0] ACCUM_MAX = '1;

	// Saturating credit accumulate, shared by all four types
	function automatic logic [rx_flags_pkg::ACCUM_W-1:0] sat_add(
		input logic [rx_flags_pkg::ACCUM_W-1:0] acc,
		input logic [rx_flags_pkg::COUNT_W-1:0] inc
	);
		logic [rx_flags_pkg::ACCUM_W:0] sum;
		sum = {1'b0, acc} + {5'h00, inc};
		if (sum[rx_flags_pkg::ACCUM_W])
			return ACCUM_MAX;
		return sum[rx_flags_pkg::ACCUM_W-1:0];
	endfunction

	// Fold 64-bit pairs onto their lower region bit
	function automatic logic [rx_flags_pkg::REGION_W-1:0] fold_region(
		input logic [rx_flags_pkg::REGION_W-1:0] match,
		input logic [2:0] pair64
	);
		logic [rx_flags_pkg::REGION_W-1:0] res;
		res = match;
		for (int p = 0; p < 3; p++) begin
			if (pair64[p]) begin
				res[2*p] = match[2*p] | match[2*p+1];
				res[2*p+1] = 1'b0;
			end
		end
		return res;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Registers
	logic [rx_flags_pkg::ACCUM_W-1:0] threshold;
	logic [2:0] pair64;
	logic [rx_flags_pkg::IRQ_W-1:0] irqStatus;
	logic [rx_flags_pkg::IRQ_W-1:0] irqMask;
	rx_flags_pkg::bus_state_t busState;
	logic [rx_flags_pkg::ACCUM_W-1:0] accum [4];
	logic [3:0] pend;
	logic [3:0] fullPrev;
	logic [15:0] timerCount;
	logic timerTick;

	logic busWrite;
	logic [rx_flags_pkg::IRQ_W-1:0] irqEvents;
	logic [3:0] addEnable;
	logic [rx_flags_pkg::COUNT_W-1:0] addValue [4];
	logic issue;
	logic [1:0] issueKind;

	assign busWrite = wb_cyc_i && wb_stb_i && wb_we_i && busState == rx_flags_pkg::BUS_IDLE;

	////////////////////////////////////////////////////////////////////////////
	// Wishbone slave: ack one cycle after the request, dropped the next cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			busState <= rx_flags_pkg::BUS_IDLE;
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			case (busState)
				rx_flags_pkg::BUS_IDLE: begin
					wb_ack_o <= wb_cyc_i && wb_stb_i;
					if (wb_cyc_i && wb_stb_i)
						busState <= rx_flags_pkg::BUS_ACK;
					case (wb_adr_i)
						rx_flags_pkg::THRESHOLD_OFFSET: wb_dat_o <= {20'h00000, threshold};
						rx_flags_pkg::PAIR64_OFFSET: wb_dat_o <= {29'h00000000, pair64};
						rx_flags_pkg::IRQ_STATUS_OFFSET: wb_dat_o <= {27'h0000000, irqStatus};
						rx_flags_pkg::IRQ_MASK_OFFSET: wb_dat_o <= {27'h0000000, irqMask};
						rx_flags_pkg::PENDING_LO_OFFSET: wb_dat_o <= {4'h0, accum[1], 4'h0, accum[0]};
						rx_flags_pkg::PENDING_HI_OFFSET: wb_dat_o <= {4'h0, accum[3], 4'h0, accum[2]};
						default: wb_dat_o <= 32'h00000000;
					endcase
				end
				rx_flags_pkg::BUS_ACK: begin
					wb_ack_o <= 1'b0;
					busState <= rx_flags_pkg::BUS_IDLE;
				end
				default: begin
					wb_ack_o <= 1'b0;
					busState <= rx_flags_pkg::BUS_IDLE;
				end
			endcase
		end
	end

	// Writes land at the request edge; the ack edge follows with no further effect
	always_ff @(posedge clk) begin
		if (rst) begin
			threshold <= rx_flags_pkg::THRESHOLD_RESET;
			pair64 <= rx_flags_pkg::PAIR64_RESET;
			irqMask <= rx_flags_pkg::IRQ_MASK_RESET;
		end else if (busWrite) begin
			if (wb_adr_i == rx_flags_pkg::THRESHOLD_OFFSET) begin
				if (wb_sel_i[0])
					threshold[7:0] <= wb_dat_i[7:0];
				if (wb_sel_i[1])
					threshold[11:8] <= wb_dat_i[11:8];
			end
			if (wb_adr_i == rx_flags_pkg::PAIR64_OFFSET && wb_sel_i[0])
				pair64 <= wb_dat_i[2:0];
			if (wb_adr_i == rx_flags_pkg::IRQ_MASK_OFFSET && wb_sel_i[0])
				irqMask <= wb_dat_i[rx_flags_pkg::IRQ_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Receive flags; rx_first_beat follows the start strobe, the other flags change only with it
	always_ff @(posedge clk) begin
		if (rst) begin
			rx_first_beat <= 1'b0;
			rx_malformed_flag <= 1'b0;
			rx_unsupported_flag <= 1'b0;
			rxRegionHit <= 7'h00;
		end else begin
			rx_first_beat <= rxHdrIn.start;
			if (rxHdrIn.start) begin
				rx_malformed_flag <= rxHdrIn.lenBad | rxHdrIn.fmtBad;
				rx_unsupported_flag <= rxHdrIn.unsupType;
				rxRegionHit <= fold_region(rxHdrIn.regionMatch, pair64);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Interrupt status: sticky, write one to clear, a new event wins over the clear
	assign irqEvents = {issue,
		app_unsup_posted,
		app_unsup_nonposted,
		rxHdrIn.start & rxHdrIn.unsupType,
		rxHdrIn.start & (rxHdrIn.lenBad | rxHdrIn.fmtBad)};

	always_ff @(posedge clk) begin
		if (rst) begin
			irqStatus <= 5'h00;
		end else begin
			if (busWrite && wb_adr_i == rx_flags_pkg::IRQ_STATUS_OFFSET && wb_sel_i[0])
				irqStatus <= (irqStatus & ~wb_dat_i[rx_flags_pkg::IRQ_W-1:0]) | irqEvents;
			else
				irqStatus <= irqStatus | irqEvents;
		end
	end

	always_ff @(posedge clk) begin
		if (rst)
			irq <= 1'b0;
		else
			irq <= |(irqStatus & irqMask);
	end

	////////////////////////////////////////////////////////////////////////////
	// Credit accounting
	always_comb begin
		addEnable = {data_credit_freed_strobe[1], hdr_credit_freed_strobe[1],
			data_credit_freed_strobe[0], hdr_credit_freed_strobe[0]};
		addValue[rx_flags_pkg::FC_PH] = 8'h01;
		addValue[rx_flags_pkg::FC_NPH] = 8'h01;
		addValue[rx_flags_pkg::FC_PD] = dataCreditFreedCountP;
		addValue[rx_flags_pkg::FC_NPD] = dataCreditFreedCountNp;
	end

	// Lowest pending type goes first; at most one update per cycle
	always_comb begin
		issue = |pend;
		issueKind = 2'b00;
		for (int k = 3; k >= 0; k--) begin
			if (pend[k])
				issueKind = 2'(k);
		end
	end

	// Credits freed in the issuing cycle stay behind for the next update
	always_ff @(posedge clk) begin
		if (rst) begin
			for (int k = 0; k < 4; k++)
				accum[k] <= 12'h000;
		end else begin
			for (int k = 0; k < 4; k++) begin
				if (issue && issueKind == 2'(k))
					accum[k] <= addEnable[k] ? {4'h0, addValue[k]} : 12'h000;
				else if (addEnable[k])
					accum[k] <= sat_add(accum[k], addValue[k]);
			end
		end
	end

	// Update timer
	always_ff @(posedge clk) begin
		if (rst) begin
			timerCount <= 16'h0000;
			timerTick <= 1'b0;
		end else begin
			timerTick <= timerCount == TIMER_LAST;
			timerCount <= (timerCount == TIMER_LAST) ? 16'h0000 : timerCount + 16'h0001;
		end
	end

	// Pending triggers: buffer full edge, timer with credits, threshold reached
	always_ff @(posedge clk) begin
		if (rst) begin
			pend <= 4'h0;
			fullPrev <= 4'h0;
		end else begin
			fullPrev <= app_buffer_full;
			for (int k = 0; k < 4; k++) begin
				// The issuing kind ignores its own old total, else an empty second update follows
				if ((app_buffer_full[k] && !fullPrev[k])
						|| (!(issue && issueKind == 2'(k)) && ((timerTick && accum[k] != 12'h000)
						|| (threshold != 12'h000 && accum[k] >= threshold))))
					pend[k] <= 1'b1;
				else if (issue && issueKind == 2'(k))
					pend[k] <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			fcUpdate <= '0;
		end else begin
			fcUpdate.valid <= issue;
			fcUpdate.kind <= rx_flags_pkg::fc_kind_t'(issueKind);
			fcUpdate.credits <= accum[issueKind];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence hdrStart_s;
		rxHdrIn.start;
	endsequence

	sequence fullRisePh_s;
		app_buffer_full[0] && !fullPrev[0];
	endsequence

	sequence phUpdate_s;
		fcUpdate.valid && fcUpdate.kind == rx_flags_pkg::FC_PH;
	endsequence

	first_beat_a: assert property (hdrStart_s |=> rx_first_beat) else $error("start strobe missing");
	lone_beat_a: assert property (!rxHdrIn.start |=> !rx_first_beat) else $error("stray start strobe");
	malformed_flag_a: assert property (hdrStart_s ##0 (rxHdrIn.lenBad || rxHdrIn.fmtBad) |=>
		rx_malformed_flag && rx_first_beat) else $error("malformed flag missing");
	unsup_flag_a: assert property (hdrStart_s |=> rx_unsupported_flag == $past(rxHdrIn.unsupType))
		else $error("unsupported flag wrong");
	region_hit_a: assert property (hdrStart_s ##0 (pair64 == 3'h0) |=>
		rxRegionHit == $past(rxHdrIn.regionMatch)) else $error("region hit wrong");
	pair_lower_a: assert property (hdrStart_s ##0 (pair64[0] && rxHdrIn.regionMatch[1]) |=>
		rxRegionHit[0] && !rxRegionHit[1]) else $error("pair hit not on lower bit");
	flags_stable_a: assert property (!rxHdrIn.start |=> $stable(rxRegionHit) && $stable(rx_malformed_flag)
		&& $stable(rx_unsupported_flag)) else $error("flags moved inside a TLP");
	buffer_full_a: assert property (fullRisePh_s |-> ##[1:2] phUpdate_s)
		else $error("buffer full update late");
	hdr_count_a: assert property (hdr_credit_freed_strobe[0] && !pend[0] && accum[0] < 12'hffe |=>
		accum[0] == $past(accum[0]) + 12'h001) else $error("header credit not counted");
	data_count_a: assert property (data_credit_freed_strobe[0] && !pend[1] && accum[1] < 12'hf00 |=>
		accum[1] == $past(accum[1]) + {4'h0, $past(dataCreditFreedCountP)})
		else $error("data credit not counted");
	threshold_fc_a: assert property (threshold != 12'h000 && accum[2] >= threshold |-> ##[1:6]
		(fcUpdate.valid && fcUpdate.kind == rx_flags_pkg::FC_NPH)) else $error("threshold update late");
	timer_fc_a: assert property (timerTick && accum[3] != 12'h000 |-> ##[1:6]
		(fcUpdate.valid && fcUpdate.kind == rx_flags_pkg::FC_NPD)) else $error("timer update late");

endmodule

// ### verif/app_partner.sv
/*
 Model of the user application logic that frees receive credits and flags refused requests.
 Assumes it shares clk with the block and that the bench calls its tasks one at a time.
*/
`timescale 1ns/10ps
module app_partner (
	// Clock
	input wire logic clk,
	// Toward the block
	output logic app_unsup_nonposted,
	output logic app_unsup_posted,
	output logic [3:0] app_buffer_full,
	output logic [1:0] hdr_credit_freed_strobe,
	output logic [1:0] data_credit_freed_strobe,
	output logic [rx_flags_pkg::COUNT_W-1:0] dataCreditFreedCountP,
	output logic [rx_flags_pkg::COUNT_W-1:0] dataCreditFreedCountNp
);
	logic [7:0] heldCount = 8'h00;
	logic [15:0] noise = 16'h0000;
	integer seed = 65;

	////////////////////////////////////////////////////////////////////////////
	// Outside the strobe cycle the count is junk, so a late sample shows up
	assign dataCreditFreedCountP = data_credit_freed_strobe[0] ? heldCount : noise[7:0];
	assign dataCreditFreedCountNp = data_credit_freed_strobe[1] ? heldCount : noise[15:8];

	initial begin
		app_unsup_nonposted = 1'b0;
		app_unsup_posted = 1'b0;
		app_buffer_full = 4'h0;
		hdr_credit_freed_strobe = 2'h0;
		data_credit_freed_strobe = 2'h0;
	end

	always @(posedge clk) begin
		noise <= 16'($random(seed));
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic free_hdr(input int k, input int n);
		@(posedge clk);
		hdr_credit_freed_strobe[k] <= 1'b1;
		repeat (n) @(posedge clk);
		hdr_credit_freed_strobe[k] <= 1'b0;
	endtask

	task automatic free_data(input int k, input logic [7:0] c);
		@(posedge clk);
		data_credit_freed_strobe[k] <= 1'b1;
		heldCount <= c;
		@(posedge clk);
		data_credit_freed_strobe[k] <= 1'b0;
	endtask

	task automatic set_full(input int k, input logic v);
		@(posedge clk);
		app_buffer_full[k] <= v;
	endtask

	task automatic flag_unsup(input logic np);
		@(posedge clk);
		if (np) app_unsup_nonposted <= 1'b1;
		else app_unsup_posted <= 1'b1;
		@(posedge clk);
		app_unsup_nonposted <= 1'b0;
		app_unsup_posted <= 1'b0;
	endtask
endmodule

// ### verif/tb_rx_tlp_flags_credit_return.sv
/*
 Self-checking bench for the receive flag and credit return block.
 Assumes the application model app_partner and a short update timer for quick runs.
*/
`timescale 1ns/10ps
module tb_rx_tlp_flags_credit_return;
	localparam int TIMER = 16;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] datW = 32'h0;
	logic [31:0] datR;
	logic ack;
	rx_flags_pkg::rx_hdr_t rxHdr = '0;
	logic firstBeat, malf, unsup, irq, unsupNp, unsupP;
	logic [rx_flags_pkg::REGION_W-1:0] hit;
	logic [3:0] bufFull;
	logic [1:0] hdrStb, dataStb;
	logic [7:0] cntP, cntNp;
	rx_flags_pkg::fc_update_t fcUp;
	logic [31:0] expRd[$];
	logic [13:0] expFc[$];
	logic [8:0] expRx[$];
	logic [8:0] lastRx = 9'h000;
	logic [2:0] pair = 3'h0;
	logic malfSeen = 1'b0;
	logic unsupSeen = 1'b0;
	int bad_count = 0;
	int check_count = 0;
	integer seed = 65;
	logic [31:0] r = 32'h0;

	always #25 clk = ~clk;

	app_partner u_app (.clk(clk), .app_unsup_nonposted(unsupNp), .app_unsup_posted(unsupP),
		.app_buffer_full(bufFull), .hdr_credit_freed_strobe(hdrStb), .data_credit_freed_strobe(dataStb),
		.dataCreditFreedCountP(cntP), .dataCreditFreedCountNp(cntNp));

	rx_tlp_flags_credit_return #(.TIMER_CYCLES(TIMER)) DUT (.clk(clk), .rst(rst), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(datW), .wb_dat_o(datR),
		.wb_ack_o(ack), .rxHdrIn(rxHdr), .rx_first_beat(firstBeat), .rx_malformed_flag(malf),
		.rx_unsupported_flag(unsup), .rxRegionHit(hit), .app_unsup_nonposted(unsupNp),
		.app_unsup_posted(unsupP), .app_buffer_full(bufFull), .hdr_credit_freed_strobe(hdrStb),
		.data_credit_freed_strobe(dataStb), .dataCreditFreedCountP(cntP), .dataCreditFreedCountNp(cntNp),
		.fcUpdate(fcUp), .irq(irq));

	////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	// Classic single cycle; the request holds until ack is sampled
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		datW <= d;
		@(posedge clk);
		while (ack !== 1'b1) begin
			@(posedge clk);
		end
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		expRd.push_back(e);
		wb(1'b0, a, 32'h0);
	endtask

	// Start a burst just after a timer tick so it lands whole in one update
	task automatic sync_tick();
		@(posedge clk);
		while (DUT.timerTick !== 1'b1) begin
			@(posedge clk);
		end
	endtask

	function automatic logic [6:0] fold(input logic [6:0] m);
		fold = m;
		for (int p = 0; p < 3; p++) begin
			if (pair[p]) begin
				fold[2*p] = m[2*p] | m[2*p+1];
				fold[2*p+1] = 1'b0;
			end
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Result watcher: each appearing result consumes the oldest note
	always @(posedge clk) begin
		if (!rst) begin
			if (ack === 1'b1 && !we) begin
				if (expRd.size() == 0) check(1, 0);
				else check(datR, expRd.pop_front());
			end
			if (fcUp.valid === 1'b1) begin
				if (expFc.size() == 0) check(1, 0);
				else check(32'({fcUp.kind, fcUp.credits}), 32'(expFc.pop_front()));
			end
			if (firstBeat === 1'b1) begin
				if (expRx.size() == 0) check(1, 0);
				else begin
					lastRx = expRx.pop_front();
					check(32'({malf, unsup, hit}), 32'(lastRx));
				end
			end else check(32'({malf, unsup, hit}), 32'(lastRx));
		end
	end

	initial begin
		repeat (6000) @(posedge clk);
		bad_count++;
		summarize();
	end

	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rd(rx_flags_pkg::THRESHOLD_OFFSET, 32'h20);
		rd(rx_flags_pkg::IRQ_MASK_OFFSET, 32'h0);
		wb(1'b1, 8'h18, 32'hffffffff);
		rd(8'h18, 32'h0);
		// First pass with no pairs, second with pair 0 always folded
		for (int pass = 0; pass < 2; pass++) begin
			if (pass == 1) begin
				pair = 3'($random(seed)) | 3'h1;
				wb(1'b1, rx_flags_pkg::PAIR64_OFFSET, {29'h0, pair});
				rd(rx_flags_pkg::PAIR64_OFFSET, {29'h0, pair});
			end
			for (int i = 0; i < 30; i++) begin
				r = $random(seed);
				@(posedge clk);
				rxHdr <= r[10:0];
				if (r[10]) begin
					expRx.push_back({r[8] | r[7], r[9], fold(r[6:0])});
					malfSeen |= r[8] | r[7];
					unsupSeen |= r[9];
				end
			end
			@(posedge clk);
			rxHdr <= '0;
		end
		// Header credits: the timer sends them, the threshold is far off
		for (int k = 0; k < 2; k++) begin
			r = ($random(seed) & 3) + 1;
			expFc.push_back({k ? rx_flags_pkg::FC_NPH : rx_flags_pkg::FC_PH, r[11:0]});
			sync_tick();
			u_app.free_hdr(k, int'(r));
			repeat (TIMER + 8) @(posedge clk);
			check(32'(expFc.size()), 0);
		end
		wb(1'b1, rx_flags_pkg::THRESHOLD_OFFSET, 32'h4);
		for (int k = 0; k < 2; k++) begin
			r = k ? 32'hff : (($random(seed) & 32'h7f) | 32'h4);
			expFc.push_back({k ? rx_flags_pkg::FC_NPD : rx_flags_pkg::FC_PD, r[11:0]});
			u_app.free_data(k, r[7:0]);
			repeat (4) @(posedge clk);
			check(32'(expFc.size()), 0);
		end
		// Threshold path on non-posted headers
		sync_tick();
		expFc.push_back({rx_flags_pkg::FC_NPH, 12'h004});
		u_app.free_hdr(1, 4);
		repeat (4) @(posedge clk);
		check(32'(expFc.size()), 0);
		// Timer path on a data return below the threshold
		sync_tick();
		expFc.push_back({rx_flags_pkg::FC_NPD, 12'h002});
		u_app.free_data(1, 8'h02);
		repeat (TIMER + 4) @(posedge clk);
		check(32'(expFc.size()), 0);
		for (int k = 0; k < 4; k++) begin
			expFc.push_back({2'(k), 12'h0});
			u_app.set_full(k, 1'b1);
			repeat (4) @(posedge clk);
			check(32'(expFc.size()), 0);
			repeat (TIMER) @(posedge clk);
			u_app.set_full(k, 1'b0);
		end
		u_app.flag_unsup(1'b1);
		u_app.flag_unsup(1'b0);
		rd(rx_flags_pkg::IRQ_STATUS_OFFSET, {27'h0, 3'b111, unsupSeen, malfSeen});
		check(32'(irq), 0);
		wb(1'b1, rx_flags_pkg::IRQ_MASK_OFFSET, 32'h10);
		repeat (2) @(posedge clk);
		check(32'(irq), 1);
		wb(1'b1, rx_flags_pkg::IRQ_STATUS_OFFSET, 32'h1f);
		rd(rx_flags_pkg::IRQ_STATUS_OFFSET, 32'h0);
		check(32'(irq), 0);
		summarize();
	end
endmodule
